// [rtl/pofs_gen_counter.sv]
// one generator: down counter with queued period and two compare values
`timescale 1ns/100ps
module pofs_gen_counter #(
   parameter int WIDTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] period_pend_in,
   input wire logic [WIDTH-1:0] width_a_pend_in,
   input wire logic [WIDTH-1:0] width_b_pend_in,
   input wire logic sync_count_in,
   input wire logic update_arm_in,
   output logic zero_out,
   output logic pwm_a_out,
   output logic pwm_b_out
);
   import pofs_pkg::*;

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] period_act;
   logic [WIDTH-1:0] width_a_act;
   logic [WIDTH-1:0] width_b_act;
   logic armed;
   wire at_zero = (count == '0);
   // queued values are used already at the zero that applies them
   wire apply = at_zero && armed && !sync_count_in;
   wire [WIDTH-1:0] reload_period = apply ? period_pend_in : period_act;
   wire [WIDTH-1:0] width_a_sel = apply ? width_a_pend_in : width_a_act;
   wire [WIDTH-1:0] width_b_sel = apply ? width_b_pend_in : width_b_act;
   wire [WIDTH-1:0] reload_count = (reload_period == '0) ? '0 : reload_period - WIDTH'(1);
   wire [WIDTH-1:0] next_count = sync_count_in ? '0 :
      (at_zero ? reload_count : count - WIDTH'(1));

   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("pofs_gen_counter: unsupported WIDTH");
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count <= '0;
         period_act <= '0;
         width_a_act <= '0;
         width_b_act <= '0;
         armed <= 1'b0;
         zero_out <= 1'b0;
         pwm_a_out <= 1'b0;
         pwm_b_out <= 1'b0;
      end else begin
         count <= next_count;
         zero_out <= (next_count == '0);
         if (apply) begin
            period_act <= period_pend_in;
            width_a_act <= width_a_pend_in;
            width_b_act <= width_b_pend_in;
            armed <= update_arm_in;
         end else if (update_arm_in) begin
            armed <= 1'b1;
         end
         pwm_a_out <= (next_count < width_a_sel);
         pwm_b_out <= (next_count < width_b_sel);
      end
   end
endmodule

// [rtl/pofs_pkg.sv]
// package: constants and carriers for the pwm output fault sync stage
package pofs_pkg;
   localparam int NUM_OUTPUTS = 8;
   localparam int NUM_GENS = 4;
   localparam int TICK_WIDTH = 16;
   localparam logic [15:0] PERIOD_RESET = 16'h0000;
   localparam logic [15:0] WIDTH_RESET = 16'h0000;
   localparam logic [7:0] OUT_MASK_RESET = 8'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   typedef struct packed {
      logic [7:0] output_select_mask;
      logic output_drive_on;
      logic output_polarity_flip;
      logic fault_gate_select;
      logic fault_level_high_select;
      logic set_drive;
      logic set_polarity;
      logic set_fault_gate;
      logic set_fault_level;
   } pofs_out_cfg_s;

   typedef struct packed {
      logic write_width;
      logic [2:0] output_index;
      logic [15:0] pulse_high_ticks;
      logic write_period;
      logic [1:0] gen_index;
      logic [15:0] period_ticks;
   } pofs_value_wr_s;
endpackage

// [rtl/pofs_top.sv]
// top: settings, pending values, generators and output conditioning
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - gated outputs go to the suppressed level during fault
// - ungated outputs ignore the fault
// - default suppressed level is low
// - level select drives high on fault
// - level select needs fault gate set
// - polarity flip inverts the output
// - disabled outputs stay inactive
// - width compare sets high duration
// - readback returns last programmed width
// - only last write before the armed counter zero applies
// - sync resets selected counters together
// - queued values apply at counter zero
// - period is ticks between zero pulses
module pofs_top #(
   parameter int WIDTH = 16,
   parameter bit EXTENDED_FAULT = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire pofs_pkg::pofs_out_cfg_s out_cfg_in,
   input wire pofs_pkg::pofs_value_wr_s value_wr_in,
   input wire logic [3:0] generator_select_mask_in,
   input wire logic sync_time_base_in,
   input wire logic sync_update_in,
   input wire logic fault_active_in,
   input wire logic [2:0] read_index_in,
   output logic [15:0] width_read_out,
   output logic [15:0] period_read_out,
   output logic [3:0] gen_zero_out,
   output logic [7:0] pwm_out
);
   import pofs_pkg::*;

   logic [7:0] output_drive_on;
   logic [7:0] output_polarity_flip;
   logic [7:0] fault_gate_select;
   logic [7:0] fault_level_high_select;
   logic [15:0] width_pend [8];
   logic [15:0] period_pend [4];
   logic [7:0] raw_pwm;
   logic [7:0] next_pwm;
   wire [7:0] sel = out_cfg_in.output_select_mask;

   initial begin
      if (WIDTH != TICK_WIDTH) $error("pofs_top: WIDTH must match TICK_WIDTH");
   end

   ////////////////////////////////////////////////////////////////////////////
   // per output settings, set only where the select mask is high
   function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] m,
                                      input logic we, input logic v);
      upd = we ? ((cur & ~m) | (m & {8{v}})) : cur;
   endfunction

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         output_drive_on <= OUT_MASK_RESET;
         output_polarity_flip <= OUT_MASK_RESET;
         fault_gate_select <= OUT_MASK_RESET;
         fault_level_high_select <= OUT_MASK_RESET;
      end else begin
         output_drive_on <= upd(output_drive_on, sel, out_cfg_in.set_drive,
                                out_cfg_in.output_drive_on);
         output_polarity_flip <= upd(output_polarity_flip, sel, out_cfg_in.set_polarity,
                                     out_cfg_in.output_polarity_flip);
         fault_gate_select <= upd(fault_gate_select, sel, out_cfg_in.set_fault_gate,
                                  out_cfg_in.fault_gate_select);
         fault_level_high_select <= upd(fault_level_high_select, sel,
                                        out_cfg_in.set_fault_level && EXTENDED_FAULT,
                                        out_cfg_in.fault_level_high_select);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending values: later writes overwrite earlier ones
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_OUTPUTS; i++) width_pend[i] <= WIDTH_RESET;
         for (int g = 0; g < NUM_GENS; g++) period_pend[g] <= PERIOD_RESET;
      end else begin
         if (value_wr_in.write_width)
            width_pend[value_wr_in.output_index] <= value_wr_in.pulse_high_ticks;
         if (value_wr_in.write_period)
            period_pend[value_wr_in.gen_index] <= value_wr_in.period_ticks;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         width_read_out <= WIDTH_RESET;
         period_read_out <= PERIOD_RESET;
      end else begin
         width_read_out <= width_pend[read_index_in];
         period_read_out <= period_pend[read_index_in[1:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // generators, each feeding an output pair
   genvar g;
   generate
      for (g = 0; g < NUM_GENS; g++) begin : gen_blk
         pofs_gen_counter #(.WIDTH(WIDTH)) u_gen (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .period_pend_in(period_pend[g]),
            .width_a_pend_in(width_pend[2*g]),
            .width_b_pend_in(width_pend[2*g+1]),
            .sync_count_in(sync_time_base_in && generator_select_mask_in[g]),
            .update_arm_in(sync_update_in && generator_select_mask_in[g]),
            .zero_out(gen_zero_out[g]),
            .pwm_a_out(raw_pwm[2*g]),
            .pwm_b_out(raw_pwm[2*g+1])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // output conditioning: enable, polarity, then fault override
   wire [7:0] enabled_pwm = raw_pwm & output_drive_on;
   wire [7:0] polar_pwm = enabled_pwm ^ output_polarity_flip;
   wire [7:0] fault_hit = fault_gate_select & {8{fault_active_in}};
   wire [7:0] fault_level = fault_level_high_select & fault_gate_select;
   assign next_pwm = (polar_pwm & ~fault_hit) | (fault_level & fault_hit);

   always_ff @(posedge clk_in) begin
      if (rst_in) pwm_out <= OUT_MASK_RESET;
      else pwm_out <= next_pwm;
   end
endmodule

// [verif/pofs_gate_drv.sv]
// gate driver model: counts high ticks seen on output leg 0
`timescale 1ns/100ps
module pofs_gate_drv (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic [7:0] gate_in,
   output logic [15:0] hi_ticks_out
);
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         hi_ticks_out <= 16'h0000;
      end else begin
         hi_ticks_out <= hi_ticks_out + {15'h0000, gate_in[0]};
      end
   end
endmodule

// [verif/pofs_top_asserts.sv]
// checker: port-level assertions for the output stage
`timescale 1ns/100ps
module pofs_top_asserts #(
   parameter bit EXTENDED_FAULT = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire pofs_pkg::pofs_out_cfg_s out_cfg_in,
   input wire pofs_pkg::pofs_value_wr_s value_wr_in,
   input wire logic [3:0] generator_select_mask_in,
   input wire logic sync_time_base_in,
   input wire logic fault_active_in,
   input wire logic [2:0] read_index_in,
   input wire logic [15:0] width_read_out,
   input wire logic [15:0] period_read_out,
   input wire logic [3:0] gen_zero_out,
   input wire logic [7:0] pwm_out
);
   import pofs_pkg::*;
   logic [7:0] drv, flp, gat, lvl, next_drv, next_flp, next_gat, next_lvl;
   wire [7:0] msk = out_cfg_in.output_select_mask;
   function automatic logic [7:0] upd(input logic [7:0] o, input logic s, input logic v);
      return s ? ((msk & {8{v}}) | (o & ~msk)) : o;
   endfunction
   assign next_drv = upd(drv, out_cfg_in.set_drive, out_cfg_in.output_drive_on);
   assign next_flp = upd(flp, out_cfg_in.set_polarity, out_cfg_in.output_polarity_flip);
   assign next_gat = upd(gat, out_cfg_in.set_fault_gate, out_cfg_in.fault_gate_select);
   assign next_lvl = upd(lvl, out_cfg_in.set_fault_level && EXTENDED_FAULT,
                         out_cfg_in.fault_level_high_select);
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         {drv, flp, gat, lvl} <= 32'h0000_0000;
      end else begin
         {drv, flp, gat, lvl} <= {next_drv, next_flp, next_gat, next_lvl};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_reset_pwm;
      $fell(rst_in) |-> pwm_out == 8'h00;
   endproperty
   a_reset_pwm: assert property (p_reset_pwm) else $error("pwm not clear");
   property p_reset_read;
      $fell(rst_in) |-> width_read_out == 16'h0000 && period_read_out == 16'h0000;
   endproperty
   a_reset_read: assert property (p_reset_read) else $error("read not clear");
   property p_width_read;
      (value_wr_in.write_width && value_wr_in.output_index == read_index_in)
         ##1 (!value_wr_in.write_width && $stable(read_index_in))
         |=> width_read_out == $past(value_wr_in.pulse_high_ticks, 2);
   endproperty
   a_width_read: assert property (p_width_read) else $error("width read");
   property p_period_read;
      (value_wr_in.write_period && value_wr_in.gen_index == read_index_in[1:0])
         ##1 (!value_wr_in.write_period && $stable(read_index_in))
         |=> period_read_out == $past(value_wr_in.period_ticks, 2);
   endproperty
   a_period_read: assert property (p_period_read) else $error("period read");
   property p_sync_zero;
      sync_time_base_in |-> ##[1:2]
         ((gen_zero_out & generator_select_mask_in) == generator_select_mask_in);
   endproperty
   a_sync_zero: assert property (p_sync_zero) else $error("sync zero");
   property p_fault_level;
      (fault_active_in && $stable({drv, flp, gat, lvl}))[*3] |-> (pwm_out & gat) == (lvl & gat);
   endproperty
   a_fault_level: assert property (p_fault_level) else $error("fault");
   property p_idle_level;
      (!fault_active_in && $stable({drv, flp, gat, lvl}))[*3] |-> ((pwm_out ^ flp) & ~drv) == 8'h00;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level");
   property p_gate_needed;
      (fault_active_in && $stable({drv, flp, gat, lvl}))[*3]
         |-> ((pwm_out ^ flp) & ~drv & ~gat) == 8'h00;
   endproperty
   a_gate_needed: assert property (p_gate_needed) else $error("ungated level");
endmodule
bind pofs_top pofs_top_asserts #(.EXTENDED_FAULT(EXTENDED_FAULT)) u_asserts (
   .clk_in, .rst_in, .out_cfg_in, .value_wr_in,
   .generator_select_mask_in, .sync_time_base_in, .fault_active_in, .read_index_in,
   .width_read_out, .period_read_out, .gen_zero_out, .pwm_out);

// [verif/pwm_output_fault_sync_stage_tb.sv]
// testbench: readback, update, sync and fault scenarios
`timescale 1ns/100ps
module pwm_output_fault_sync_stage_tb;
   import pofs_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   pofs_out_cfg_s cfg = '0;
   pofs_value_wr_s vw = '0;
   logic sy_tb = 1'b0;
   logic sy_up = 1'b0;
   logic fault = 1'b0;
   logic clr = 1'b0;
   logic [3:0] gsel = 4'hF;
   logic [2:0] ridx = 3'h0;
   logic [15:0] wrd, prd, hi;
   logic [3:0] gz;
   logic [7:0] pwm;
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   pofs_top DUT (.clk_in(clk_in), .rst_in(rst_in), .out_cfg_in(cfg), .value_wr_in(vw),
      .generator_select_mask_in(gsel), .sync_time_base_in(sy_tb), .sync_update_in(sy_up),
      .fault_active_in(fault), .read_index_in(ridx), .width_read_out(wrd),
      .period_read_out(prd), .gen_zero_out(gz), .pwm_out(pwm));
   pofs_gate_drv u_drv (.clk_in(clk_in), .clr_in(clr), .gate_in(pwm), .hi_ticks_out(hi));
   initial forever #50 clk_in = ~clk_in;
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task set_cfg(input logic [7:0] m, input logic [3:0] st, input logic [3:0] v);
      @(posedge clk_in) cfg <= {m, v, st};
      @(posedge clk_in) cfg <= '0;
   endtask
   task wr(input logic ww, input logic [2:0] i, input logic [15:0] d);
      @(posedge clk_in) vw <= {ww, i, d, !ww, i[1:0], d};
      @(posedge clk_in) vw <= '0;
   endtask
   task pulse(input logic up);
      @(posedge clk_in) {sy_up, sy_tb} <= {up, !up};
      @(posedge clk_in) {sy_up, sy_tb} <= 2'b00;
   endtask
   task wz(input int e);
      n = 0;
      do begin
         @(posedge clk_in) #1 n++;
      end while (gz[0] !== 1'b1 && n < 40);
      if (n >= 40) begin
         bad_count++;
         test_done;
      end
      if (e > 0) chk("zero spacing", e[15:0], n[15:0]);
   endtask
   task cnt(input logic [15:0] e);
      @(posedge clk_in) clr <= 1'b1;
      @(posedge clk_in) clr <= 1'b0;
      repeat (8) @(posedge clk_in);
      #1 chk("high ticks", e, hi);
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      #1 chk("pwm reset", 16'h0000, {8'h00, pwm});
      wr(1'b1, 3'h0, 16'h0005);
      wr(1'b1, 3'h0, 16'h0007);
      wr(1'b0, 3'h0, 16'h0004);
      wr(1'b0, 3'h0, 16'h0008);
      wr(1'b0, 3'h1, 16'h0008);
      repeat (2) @(posedge clk_in);
      #1 chk("width read", 16'h0007, wrd);
      chk("period read", 16'h0008, prd);
      @(posedge clk_in) ridx <= 3'h1;
      repeat (2) @(posedge clk_in);
      #1 chk("width read 1", 16'h0000, wrd);
      chk("period read 1", 16'h0008, prd);
      $display("test readback done");
      set_cfg(8'h01, 4'h8, 4'h8);
      pulse(1'b1);
      repeat (3) @(posedge clk_in);
      wz(0);
      wz(8);
      cnt(16'h0007);
      @(posedge clk_in) gsel <= 4'h1;
      @(posedge clk_in);
      pulse(1'b0);
      #1 chk("sync zero", 16'h0001, {14'h0000, gz[1:0]});
      $display("test update and sync done");
      set_cfg(8'h03, 4'h2, 4'h2);
      set_cfg(8'h05, 4'h1, 4'h1);
      set_cfg(8'h80, 4'h4, 4'h4);
      @(posedge clk_in) fault <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk("fault pwm", 16'h0081, {8'h00, pwm});
      chk("fault pol", 16'h0080, {8'h00, pwm & 8'h84});
      set_cfg(8'h01, 4'h2, 4'h0);
      cnt(16'h0007);
      $display("test fault done");
      @(posedge clk_in) rst_in <= 1'b1;
      @(posedge clk_in) rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk("pwm after reset", 16'h0000, {8'h00, pwm});
      chk("period after reset", 16'h0000, prd);
      $display("test reset done");
      test_done;
   end
endmodule
